// [dv/testbench.sv]
// testbench: register-level tests of the channel power block
`timescale 1ns/10ps
module testbench;
   logic clk;
   logic sys_rst;
   logic reset_pin_n;
   logic clk_en;
   vcm_pkg::vcm_reg_req_s reg_req;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic [7:0] amp_ready;
   logic [7:0] zero_cross;
   logic [7:0] amp_power_en;
   vcm_pkg::vcm_ch_applied_s [7:0] ch_applied;
   logic [2:0][7:0] master_vol;
   logic [2:0] master_qdb;
   int miscompares = 0;
   int total_checks = 0;

   vcm_channel_power dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reset_pin_n(reset_pin_n),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .amp_ready(amp_ready),
      .zero_cross(zero_cross), .amp_power_en(amp_power_en), .ch_applied(ch_applied),
      .master_vol(master_vol), .master_qdb(master_qdb));
   vcm_analog_model model_u (.clk(clk), .sys_rst(sys_rst), .amp_power_en(amp_power_en),
      .amp_ready(amp_ready), .zero_cross(zero_cross));

   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // strobes drop a cycle before the next request, so no signal is driven twice in one step
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      reg_req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(negedge clk);
      reg_req = '0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] exp, input logic v);
      reg_req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
      @(negedge clk);
      reg_req = '0;
      check({7'h00, reg_rvalid}, {7'h00, v});
      if (v) begin
         check(reg_rdata, exp);
      end
      @(negedge clk);
   endtask

   task automatic wait_amp(input logic [7:0] exp);
      for (int n = 0; n < 60 && amp_power_en !== exp; n++) begin
         @(negedge clk);
      end
      check(amp_power_en, exp);
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      sys_rst = 1'h1;
      clk_en = 1'h1;
      reset_pin_n = 1'h0;
      reg_req = '0;
      repeat (12) @(negedge clk);
      sys_rst = 1'h0;
      repeat (4) @(negedge clk);
      wr(5'h0E, 8'h00);
      rd(5'h0E, 8'h00, 1'h0);
      check(amp_power_en, 8'h00);
      reset_pin_n = 1'h1;
      repeat (6) @(negedge clk);
      $display("test pin_reset finished");
      rd(5'h0D, 8'h00, 1'h1);
      rd(5'h0E, 8'h01, 1'h1);
      rd(5'h1C, 8'h00, 1'h1);
      for (int k = 0; k < 3; k++) begin
         rd(5'h10 + 5'(3 * k), 8'hFF, 1'h1);
      end
      // a frozen block must not take a write
      clk_en = 1'h0;
      wr(5'h0D, 8'hAA);
      clk_en = 1'h1;
      rd(5'h0D, 8'h00, 1'h1);
      $display("test defaults finished");
      wr(5'h01, 8'h33);
      wr(5'h09, 8'h01);
      wr(5'h0D, 8'h02);
      wr(5'h13, 8'h0F);
      wr(5'h11, 8'h40);
      wr(5'h12, 8'h01);
      rd(5'h13, 8'h0F, 1'h1);
      check(master_vol[0], 8'h40);
      check({7'h00, master_qdb[0]}, 8'h01);
      repeat (20) @(negedge clk);
      check(amp_power_en, 8'h00);
      $display("test configure finished");
      wr(5'h0E, 8'h00);
      wait_amp(8'hFD);
      repeat (25) @(negedge clk);
      check(ch_applied[0].vol, 8'h33);
      check({7'h00, ch_applied[0].mute}, 8'h00);
      check({7'h00, ch_applied[1].mute}, 8'h01);
      check({5'h00, ch_applied[4].master_conn}, 8'h05);
      check({5'h00, ch_applied[3].master_conn}, 8'h07);
      check({7'h00, ch_applied[0].qdb}, 8'h01);
      rd(5'h19, 8'hFD, 1'h1);
      wr(5'h15, 8'h02);
      check({7'h00, ch_applied[3].mute}, 8'h01);
      check({7'h00, ch_applied[4].mute}, 8'h00);
      wr(5'h15, 8'h00);
      check({7'h00, ch_applied[3].mute}, 8'h00);
      wr(5'h0F, 8'h01);
      wr(5'h0D, 8'h03);
      wait_amp(8'hFC);
      check({7'h00, ch_applied[0].mute}, 8'h01);
      wr(5'h0F, 8'h00);
      wr(5'h0E, 8'h01);
      wait_amp(8'h00);
      $display("test power_sequence finished");
      reset_pin_n = 1'h0;
      repeat (10) @(negedge clk);
      reset_pin_n = 1'h1;
      repeat (6) @(negedge clk);
      rd(5'h0D, 8'h00, 1'h1);
      rd(5'h13, 8'hFF, 1'h1);
      rd(5'h0E, 8'h01, 1'h1);
      $display("test pin_restore finished");
      report_and_stop();
   end
endmodule

// [dv/vcm_analog_model.sv]
// analog side model: amplifier settle delay and periodic zero-crossing indications
`timescale 1ns/10ps
module vcm_analog_model (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // amplifier side
   input wire logic [7:0] amp_power_en,
   output logic [7:0] amp_ready,
   output logic [7:0] zero_cross
);
   logic [5:0][7:0] settle_ff;
   logic [3:0] zc_cnt_ff;

   // ready drops at once on power-off; after an off time under 6 cycles settle_ff[5] still holds the old ready at the next power-up
   assign amp_ready = settle_ff[5] & amp_power_en;
   // crossings held 4 cycles so the block's agree filter sees them
   assign zero_cross = {8{zc_cnt_ff[3:2] == 2'h3}};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         settle_ff <= '0;
         zc_cnt_ff <= '0;
      end else begin
         settle_ff <= {settle_ff[4:0], amp_power_en};
         zc_cnt_ff <= zc_cnt_ff + 4'h1;
      end
   end
endmodule

// [dv/vcm_channel_power_assertions.sv]
// checker: port-level properties of the channel power block
`timescale 1ns/10ps
module vcm_power_chk #(
   parameter int NUM_CH = 8,
   parameter int NUM_MASTER = 3
) (
   // clock and resets
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic reset_pin_n,
   // register port
   input wire vcm_pkg::vcm_reg_req_s reg_req,
   input wire logic [vcm_pkg::DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   // analog side
   input wire logic [NUM_CH-1:0] amp_ready,
   input wire logic [NUM_CH-1:0] zero_cross,
   input wire logic [NUM_CH-1:0] amp_power_en,
   input wire vcm_pkg::vcm_ch_applied_s [NUM_CH-1:0] ch_applied,
   input wire logic [NUM_MASTER-1:0][vcm_pkg::DATA_W-1:0] master_vol,
   input wire logic [NUM_MASTER-1:0] master_qdb
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence pin_up_s;
      reset_pin_n [*6];
   endsequence

   AST_PIN_LOW_OFF: assert property ((!reset_pin_n) [*8] |-> amp_power_en == '0 && !reg_rvalid)
      else $error("amplifier on or read answered under reset pin");
   AST_RVALID_CAUSE: assert property (reg_rvalid |-> $past(reg_req.rd))
      else $error("read data flagged without a read");
   AST_READ_ANSWER: assert property (pin_up_s ##0 reg_req.rd |=> reg_rvalid)
      else $error("read not answered after reset pin release");

   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      // pin reset may cut power without the mute step, so those cycles are excluded
      AST_UP_MUTED: assert property (disable iff (sys_rst || !reset_pin_n)
         $rose(amp_power_en[i]) |-> ch_applied[i].mute) else $error("channel unmuted at power-up");
      AST_OFF_AFTER_MUTE: assert property (disable iff (sys_rst || !reset_pin_n)
         $fell(amp_power_en[i]) |-> $past(ch_applied[i].mute)) else $error("power cut before mute");
      AST_SOUND_NEEDS_POWER: assert property (disable iff (sys_rst || !reset_pin_n)
         !ch_applied[i].mute |-> amp_power_en[i]) else $error("unmuted channel without power");
   end

   for (genvar k = 0; k < NUM_MASTER; k++) begin : g_m
      AST_MASTER_VOL_BY_WRITE: assert property (disable iff (sys_rst || !reset_pin_n)
         $changed(master_vol[k]) |-> $past(reg_req.wr && reg_req.addr == 5'(17 + 3 * k)))
         else $error("master volume changed without its write");
      AST_MASTER_QDB_BY_WRITE: assert property (disable iff (sys_rst || !reset_pin_n)
         $changed(master_qdb[k]) |-> $past(reg_req.wr && reg_req.addr == 5'(18 + 3 * k)))
         else $error("master quarter step changed without its write");
   end
endmodule

bind vcm_channel_power vcm_power_chk #(.NUM_CH(NUM_CH), .NUM_MASTER(NUM_MASTER)) chk_u (.clk(clk),
   .sys_rst(sys_rst), .clk_en(clk_en), .reset_pin_n(reset_pin_n), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .amp_ready(amp_ready), .zero_cross(zero_cross),
   .amp_power_en(amp_power_en), .ch_applied(ch_applied), .master_vol(master_vol), .master_qdb(master_qdb));

// [hdl/vcm_channel_power.sv]
// channel power sequencing, zero-crossing application of mute and volume, and master mask routing
`timescale 1ns/10ps

// Overview of operation
// - reset pin low: powered down, port ignored
// - global power-down set keeps all amplifiers off
// - power up only when both bits clear
// - reset: channel bits clear, global bit set
// - mute during power-up, then apply settings
// - either bit set powers channel down
// - mute channel before amplifier power-down; a reset pin low cuts power without the mute step
// - power mutes follow zero-crossing mode
// - reset pin low restores register defaults
// - configure under global power-down, clear starts
// - eight individual controls, one per channel
// - three masters change whole group at once
// - mask bit connects channel, default all
// - mask gates master volume and mute
// - master masks at 10h, 13h, 16h
// - channel power-down bits at 0Dh
module vcm_channel_power #(
   parameter int NUM_CH = vcm_pkg::NUM_CH,
   parameter int NUM_MASTER = vcm_pkg::NUM_MASTER
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // device reset pin, active low
   input wire logic reset_pin_n,
   // control port register access
   input wire vcm_pkg::vcm_reg_req_s reg_req,
   output logic [vcm_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // analog side status pins
   input wire logic [NUM_CH-1:0] amp_ready,
   input wire logic [NUM_CH-1:0] zero_cross,
   // analog side controls
   output logic [NUM_CH-1:0] amp_power_en,
   output vcm_pkg::vcm_ch_applied_s [NUM_CH-1:0] ch_applied,
   output logic [NUM_MASTER-1:0][vcm_pkg::DATA_W-1:0] master_vol,
   output logic [NUM_MASTER-1:0] master_qdb
);
   localparam int DW = vcm_pkg::DATA_W;
   localparam int AW = vcm_pkg::ADDR_W;
   localparam int NSYNC = 2 * NUM_CH + 1;

   if (NUM_CH != vcm_pkg::NUM_CH || NUM_MASTER != vcm_pkg::NUM_MASTER) begin : g_check
      $error("register map serves exactly eight channels and three masters");
   end

   // reset default of each register offset
   function automatic logic [DW-1:0] reg_default(input logic [AW-1:0] a);
      if (a == vcm_pkg::ADDR_CHANNEL_POWER_DOWN) begin
         reg_default = vcm_pkg::RST_CHANNEL_POWER_DOWN;
      end else if (a == vcm_pkg::ADDR_GLOBAL_CTRL) begin
         reg_default = vcm_pkg::RST_GLOBAL_CTRL;
      end else if (a == vcm_pkg::ADDR_MASTER_ONE_CHANNEL_MASK || a == vcm_pkg::ADDR_MASTER_TWO_CHANNEL_MASK ||
                   a == vcm_pkg::ADDR_MASTER_THREE_CHANNEL_MASK) begin
         reg_default = vcm_pkg::RST_MASTER_MASK;
      end else begin
         reg_default = vcm_pkg::RST_OTHER;
      end
   endfunction

   // offsets that software may write
   function automatic logic reg_writable(input logic [AW-1:0] a);
      reg_writable = (a >= vcm_pkg::ADDR_CH_VOL_FIRST && a <= vcm_pkg::ADDR_CH_MUTE) ||
                     (a >= vcm_pkg::ADDR_CHANNEL_POWER_DOWN && a <= vcm_pkg::ADDR_MASTER_LAST);
   endfunction

   // ---------------- pin synchronisers ----------------
   // three stages; the filtered copy only moves when stages two and three agree
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   logic [NSYNC-1:0] sync3_ff;
   logic [NSYNC-1:0] filt_ff;
   wire [NSYNC-1:0] pins_in = {reset_pin_n, zero_cross, amp_ready};
   wire [NSYNC-1:0] sync_agree = ~(sync2_ff ^ sync3_ff);
   wire [NSYNC-1:0] nxt_filt = (sync_agree & sync3_ff) | (~sync_agree & filt_ff);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
         filt_ff <= '0;
      end else if (clk_en) begin
         sync1_ff <= pins_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         filt_ff <= nxt_filt;
      end
   end

   wire [NUM_CH-1:0] amp_ready_s = filt_ff[NUM_CH-1:0];
   wire [NUM_CH-1:0] zero_cross_s = filt_ff[2*NUM_CH-1:NUM_CH];
   wire dev_run = filt_ff[NSYNC-1];

   // ---------------- register file ----------------
   logic [DW-1:0] regs_ff [0:vcm_pkg::REG_DEPTH-1];
   // accesses are dropped while the device is held in reset
   wire wr_hit = reg_req.wr & dev_run & reg_writable(reg_req.addr);
   wire rd_take = reg_req.rd & dev_run;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int a = 0; a < vcm_pkg::REG_DEPTH; a++) begin
            regs_ff[a] <= reg_default(AW'(a));
         end
      end else if (clk_en) begin
         for (int a = 0; a < vcm_pkg::REG_DEPTH; a++) begin
            if (!dev_run) begin
               regs_ff[a] <= reg_default(AW'(a));
            end else if (wr_hit && reg_req.addr == AW'(a)) begin
               regs_ff[a] <= reg_req.wdata;
            end
         end
      end
   end

   // decoded fields, bit n steers channel n+1
   wire global_power_down = regs_ff[vcm_pkg::ADDR_GLOBAL_CTRL][vcm_pkg::GLOBAL_POWER_DOWN_POS];
   wire [NUM_CH-1:0] channel_power_down_bit = regs_ff[vcm_pkg::ADDR_CHANNEL_POWER_DOWN];
   wire [NUM_CH-1:0] ch_mute_bit = regs_ff[vcm_pkg::ADDR_CH_MUTE];
   wire [NUM_CH-1:0] ch_qdb_bit = regs_ff[vcm_pkg::ADDR_QUARTER_DB];
   wire zc_enable = regs_ff[vcm_pkg::ADDR_ZC_CTRL][vcm_pkg::ZC_ENABLE_POS];

   logic [NUM_MASTER-1:0][NUM_CH-1:0] master_mask;
   logic [NUM_MASTER-1:0] master_mute;
   always_comb begin
      for (int m = 0; m < NUM_MASTER; m++) begin
         // volume and control registers follow each mask
         master_mask[m] = regs_ff[vcm_pkg::ADDR_MASTER_ONE_CHANNEL_MASK + AW'(m) * vcm_pkg::MASTER_STRIDE];
         master_vol[m] = regs_ff[vcm_pkg::ADDR_MASTER_ONE_CHANNEL_MASK + AW'(m) * vcm_pkg::MASTER_STRIDE +
                                 vcm_pkg::MASTER_VOL_OFS];
         master_qdb[m] = regs_ff[vcm_pkg::ADDR_MASTER_ONE_CHANNEL_MASK + AW'(m) * vcm_pkg::MASTER_STRIDE +
                                 vcm_pkg::MASTER_CTL_OFS][vcm_pkg::MASTER_QDB_POS];
         master_mute[m] = regs_ff[vcm_pkg::ADDR_MASTER_ONE_CHANNEL_MASK + AW'(m) * vcm_pkg::MASTER_STRIDE +
                                  vcm_pkg::MASTER_CTL_OFS][vcm_pkg::MASTER_MUTE_POS];
      end
   end

   // ---------------- per-channel power sequencing ----------------
   vcm_pkg::vcm_ch_state_e state_ff [NUM_CH];
   vcm_pkg::vcm_ch_state_e nxt_state [NUM_CH];
   vcm_pkg::vcm_ch_applied_s [NUM_CH-1:0] target;
   logic [NUM_CH-1:0] want_on;
   logic [NUM_CH-1:0] force_mute;
   logic [NUM_CH-1:0] apply_now;

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         want_on[c] = dev_run & ~global_power_down & ~channel_power_down_bit[c];
         force_mute[c] = (state_ff[c] != vcm_pkg::CH_ACTIVE);
         target[c].vol = regs_ff[vcm_pkg::ADDR_CH_VOL_FIRST + AW'(c)];
         target[c].qdb = ch_qdb_bit[c];
         for (int m = 0; m < NUM_MASTER; m++) begin
            target[c].master_conn[m] = master_mask[m][c];
         end
         // a master mute reaches only the channels its mask connects
         target[c].mute = force_mute[c] | ch_mute_bit[c] | (|(master_mute & target[c].master_conn));
         // changes wait for a zero crossing unless immediate mode is chosen or the device is held in reset
         apply_now[c] = ~zc_enable | zero_cross_s[c] | ~dev_run;
      end
   end

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         nxt_state[c] = state_ff[c];
         case (state_ff[c])
            vcm_pkg::CH_OFF: begin
               if (want_on[c]) begin
                  nxt_state[c] = vcm_pkg::CH_POWER_UP;
               end
            end
            vcm_pkg::CH_POWER_UP: begin
               // muted throughout; the mute lifts only once the amplifier reports ready
               if (!want_on[c]) begin
                  nxt_state[c] = vcm_pkg::CH_OFF;
               end else if (amp_ready_s[c]) begin
                  nxt_state[c] = vcm_pkg::CH_ACTIVE;
               end
            end
            vcm_pkg::CH_ACTIVE: begin
               if (!want_on[c]) begin
                  nxt_state[c] = vcm_pkg::CH_MUTE_DOWN;
               end
            end
            vcm_pkg::CH_MUTE_DOWN: begin
               // amplifier stays on until the mute is really in force
               if (ch_applied[c].mute) begin
                  nxt_state[c] = vcm_pkg::CH_OFF;
               end
            end
            default: begin
               nxt_state[c] = vcm_pkg::CH_OFF;
            end
         endcase
         if (!dev_run) begin
            nxt_state[c] = vcm_pkg::CH_OFF;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int c = 0; c < NUM_CH; c++) begin
            state_ff[c] <= vcm_pkg::CH_OFF;
         end
         amp_power_en <= '0;
      end else if (clk_en) begin
         for (int c = 0; c < NUM_CH; c++) begin
            state_ff[c] <= nxt_state[c];
            amp_power_en[c] <= (nxt_state[c] != vcm_pkg::CH_OFF);
         end
      end
   end

   // settings in force; start muted so a channel never powers up unmuted
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int c = 0; c < NUM_CH; c++) begin
            ch_applied[c] <= '{mute: 1'b1, master_conn: '1, qdb: 1'b0, vol: '0};
         end
      end else if (clk_en) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (apply_now[c]) begin
               ch_applied[c] <= target[c];
            end
         end
      end
   end

   // ---------------- read path ----------------
   logic [NUM_CH-1:0] ch_active;
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         ch_active[c] = (state_ff[c] == vcm_pkg::CH_ACTIVE);
      end
   end

   wire rd_status = (reg_req.addr == vcm_pkg::ADDR_CH_ACTIVE_STATUS);
   wire rd_mapped = reg_writable(reg_req.addr);
   wire [DW-1:0] rd_word = rd_status ? DW'(ch_active) : (rd_mapped ? regs_ff[reg_req.addr] : '0);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= '0;
         reg_rvalid <= 1'b0;
      end else if (clk_en) begin
         reg_rvalid <= rd_take;
         if (rd_take) begin
            reg_rdata <= rd_word;
         end
      end
   end
endmodule

// [hdl/vcm_pkg.sv]
// package: register map, field positions, reset values and types for the channel power and master mask block
package vcm_pkg;
   // geometry
   localparam int NUM_CH = 8;
   localparam int NUM_MASTER = 3;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int REG_DEPTH = 32;

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_CH_VOL_FIRST = 5'h01;
   localparam logic [ADDR_W-1:0] ADDR_CH_VOL_LAST = 5'h08;
   localparam logic [ADDR_W-1:0] ADDR_QUARTER_DB = 5'h09;
   localparam logic [ADDR_W-1:0] ADDR_CH_MUTE = 5'h0A;
   localparam logic [ADDR_W-1:0] ADDR_CHANNEL_POWER_DOWN = 5'h0D;
   localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CTRL = 5'h0E;
   localparam logic [ADDR_W-1:0] ADDR_ZC_CTRL = 5'h0F;
   localparam logic [ADDR_W-1:0] ADDR_MASTER_ONE_CHANNEL_MASK = 5'h10;
   localparam logic [ADDR_W-1:0] ADDR_MASTER_TWO_CHANNEL_MASK = 5'h13;
   localparam logic [ADDR_W-1:0] ADDR_MASTER_THREE_CHANNEL_MASK = 5'h16;
   localparam logic [ADDR_W-1:0] ADDR_MASTER_LAST = 5'h18;
   localparam logic [ADDR_W-1:0] ADDR_CH_ACTIVE_STATUS = 5'h19;
   // each master owns three consecutive offsets: mask, volume, control
   localparam logic [ADDR_W-1:0] MASTER_STRIDE = 5'h03;
   localparam logic [ADDR_W-1:0] MASTER_VOL_OFS = 5'h01;
   localparam logic [ADDR_W-1:0] MASTER_CTL_OFS = 5'h02;

   // field positions
   localparam int GLOBAL_POWER_DOWN_POS = 0;
   localparam int ZC_ENABLE_POS = 0;
   localparam int MASTER_QDB_POS = 0;
   localparam int MASTER_MUTE_POS = 1;

   // reset values
   localparam logic [DATA_W-1:0] RST_CHANNEL_POWER_DOWN = 8'h00;
   localparam logic [DATA_W-1:0] RST_GLOBAL_CTRL = 8'h01;
   localparam logic [DATA_W-1:0] RST_MASTER_MASK = 8'hFF;
   localparam logic [DATA_W-1:0] RST_OTHER = 8'h00;

   // per-channel power sequence
   typedef enum logic [1:0] {
      CH_OFF = 2'b00,
      CH_POWER_UP = 2'b01,
      CH_ACTIVE = 2'b10,
      CH_MUTE_DOWN = 2'b11
   } vcm_ch_state_e;

   // register access request from the control port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } vcm_reg_req_s;

   // settings actually in force on one channel
   typedef struct packed {
      logic mute;
      logic [NUM_MASTER-1:0] master_conn;
      logic qdb;
      logic [DATA_W-1:0] vol;
   } vcm_ch_applied_s;
endpackage
